//--- hw/adc_seq0_pkg.sv
// Constants, offsets, field positions and types for the sequence 0 control and result FIFO.
package adc_seq0_pkg;

   // ****************************************************************
   // Widths and depths
   // ****************************************************************
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned STEP_W = 3;
   localparam int unsigned MUX_W = 2;
   localparam int unsigned RESULT_W = 10;
   localparam int unsigned PTR_W = 3;
   localparam int unsigned CNT_W = 4;
   localparam int unsigned EVT_W = 3;

   localparam logic [STEP_W-1:0] LAST_STEP = 3'h7;
   localparam logic [CNT_W-1:0] FIFO_DEPTH = 4'h8;

   // ****************************************************************
   // Register offsets
   // ****************************************************************
   localparam logic [ADDR_W-1:0] OFS_START = 12'h000;
   localparam logic [ADDR_W-1:0] OFS_INT_STATUS = 12'h008;
   localparam logic [ADDR_W-1:0] OFS_INT_MASK = 12'h00c;
   localparam logic [ADDR_W-1:0] OFS_OVERFLOW = 12'h010;
   localparam logic [ADDR_W-1:0] OFS_UNDERFLOW = 12'h014;
   localparam logic [ADDR_W-1:0] OFS_INPUT_SEL = 12'h040;
   localparam logic [ADDR_W-1:0] OFS_STEP_CTRL = 12'h044;
   localparam logic [ADDR_W-1:0] OFS_RESULT = 12'h048;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int unsigned BIT_DIFF = 0;
   localparam int unsigned BIT_END = 1;
   localparam int unsigned BIT_IRQ_EN = 2;
   localparam int unsigned BIT_TEMP = 3;
   localparam int unsigned EVT_RAW = 0;
   localparam int unsigned EVT_OVF = 1;
   localparam int unsigned EVT_UNF = 2;
   localparam int unsigned BIT_GO = 0;

   // ****************************************************************
   // Reset values and write masks
   // ****************************************************************
   localparam logic [DATA_W-1:0] STEP_CTRL_RST = 32'h0000_0000;
   localparam logic [DATA_W-1:0] INPUT_SEL_RST = 32'h0000_0000;
   localparam logic [DATA_W-1:0] INPUT_SEL_WMASK = 32'h3333_3333;
   localparam logic [EVT_W-1:0] EVT_RST = 3'h0;
   localparam logic [EVT_W-1:0] MASK_RST = 3'h0;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_REQ,
      ST_WAIT
   } seq_state_e;

endpackage : adc_seq0_pkg

//--- hw/adc_seq0_ctrl.sv
// Sequence 0 step control, converter request logic, result FIFO and registers.
`timescale 1ns/10ps
`default_nettype none
//
// Contract
// - Temp bit set converts sensor, else muxed pin.
// - Step irq bit raises raw flag on completion.
// - Raw flag reaches irq only when masked in.
// - Any number of steps may raise flag.
// - End bit marks final step, any position.
// - Steps after first end are never converted.
// - Single-step sequencer holds its end bit set.
// - Differential bit samples pair 2i and 2i+1.
// - Temperature sensor is single-ended only.
// - Four bits per step: temp, irq, end, diff.
// - Result reads return steps in order.
// - Overflow and underflow recorded in separate registers.
// - Result read gives 10-bit value, low bits.
// - Reserved result bits read undefined, never written; here they read as zero.
// - Mux field value selects input of same number.
module adc_seq0_ctrl (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [adc_seq0_pkg::ADDR_W-1:0] addr_i,
   input wire logic [adc_seq0_pkg::DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [adc_seq0_pkg::DATA_W-1:0] rdata_o,
   output logic irq_o,
   output logic conv_start_o,
   output logic [adc_seq0_pkg::MUX_W-1:0] conv_input_o,
   output logic conv_temp_o,
   output logic conv_diff_o,
   input wire logic conv_done_i,
   input wire logic [adc_seq0_pkg::RESULT_W-1:0] conv_data_i
);
   import adc_seq0_pkg::*;

   // ****************************************************************
   // Registers and state
   // ****************************************************************
   logic [DATA_W-1:0] step_ctrl;
   logic [DATA_W-1:0] input_sel;
   logic [EVT_W-1:0] evt;
   logic [EVT_W-1:0] mask;
   seq_state_e state;
   logic [STEP_W-1:0] step;
   logic done_meta;
   logic done_sync;
   logic done_prev;
   logic [RESULT_W-1:0] data_meta;
   logic [RESULT_W-1:0] data_sync;
   logic [RESULT_W-1:0] fifo_mem [0:7];
   logic [PTR_W-1:0] wr_ptr;
   logic [PTR_W-1:0] rd_ptr;
   logic [CNT_W-1:0] count;

   // ****************************************************************
   // Decode
   // ****************************************************************
   wire wr_start = wr_i && (addr_i == OFS_START);
   wire wr_status = wr_i && (addr_i == OFS_INT_STATUS);
   wire wr_mask = wr_i && (addr_i == OFS_INT_MASK);
   wire wr_ovf = wr_i && (addr_i == OFS_OVERFLOW);
   wire wr_unf = wr_i && (addr_i == OFS_UNDERFLOW);
   wire wr_sel = wr_i && (addr_i == OFS_INPUT_SEL);
   wire wr_ctrl = wr_i && (addr_i == OFS_STEP_CTRL);
   wire rd_fifo = rd_i && (addr_i == OFS_RESULT);

   wire busy = (state != ST_IDLE);
   wire start_req = wr_start && wdata_i[BIT_GO];
   wire fifo_empty = (count == 4'h0);
   wire fifo_full = (count == FIFO_DEPTH);

   // One four-bit group per step, temp at top, diff at bottom.
   wire [3:0] cur_grp = step_ctrl[{step, 2'b00} +: 4];
   wire [MUX_W-1:0] cur_mux = input_sel[{step, 2'b00} +: MUX_W];

   wire done_rise = done_sync && !done_prev;
   wire step_done = (state == ST_WAIT) && done_rise;
   // The final step position is hardwired as an end, so a sequence with no end bit stops after eight steps.
   wire last_step = cur_grp[BIT_END] || (step == LAST_STEP);

   wire push = step_done && !fifo_full;
   wire overflow = step_done && fifo_full;
   wire pop = rd_fifo && !fifo_empty;
   wire underflow = rd_fifo && fifo_empty;
   wire raw_cause = step_done && cur_grp[BIT_IRQ_EN];

   wire [EVT_W-1:0] evt_set = {underflow, overflow, raw_cause};
   wire [EVT_W-1:0] evt_clr = ({EVT_W{wr_status}} & wdata_i[EVT_W-1:0])
      | ({EVT_W{wr_ovf && wdata_i[0]}} & 3'h2)
      | ({EVT_W{wr_unf && wdata_i[0]}} & 3'h4);
   // A new event in the clearing cycle survives the clear.
   wire [EVT_W-1:0] next_evt = (evt & ~evt_clr) | evt_set;

   wire [CNT_W-1:0] next_count = CNT_W'(count + {3'h0, push} - {3'h0, pop});

   // Upper result bits read as zero.
   wire [DATA_W-1:0] result_word = fifo_empty ? 32'h0000_0000
      : {22'h00_0000, fifo_mem[rd_ptr]};

   wire [DATA_W-1:0] read_value =
      (addr_i == OFS_START) ? {31'h0000_0000, busy} :
      (addr_i == OFS_INT_STATUS) ? {29'h0000_0000, evt} :
      (addr_i == OFS_INT_MASK) ? {29'h0000_0000, mask} :
      (addr_i == OFS_OVERFLOW) ? {31'h0000_0000, evt[EVT_OVF]} :
      (addr_i == OFS_UNDERFLOW) ? {31'h0000_0000, evt[EVT_UNF]} :
      (addr_i == OFS_INPUT_SEL) ? input_sel :
      (addr_i == OFS_STEP_CTRL) ? step_ctrl :
      (addr_i == OFS_RESULT) ? result_word : 32'h0000_0000;

   // ****************************************************************
   // Converter handshake synchroniser
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         done_meta <= 1'b0;
         done_sync <= 1'b0;
         done_prev <= 1'b0;
         data_meta <= 10'h000;
         data_sync <= 10'h000;
      end else begin
         done_meta <= conv_done_i;
         done_sync <= done_meta;
         done_prev <= done_sync;
         data_meta <= conv_data_i;
         data_sync <= data_meta;
      end
   end

   // ****************************************************************
   // Register file
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         step_ctrl <= STEP_CTRL_RST;
         input_sel <= INPUT_SEL_RST;
         mask <= MASK_RST;
         evt <= EVT_RST;
         rdata_o <= 32'h0000_0000;
         irq_o <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            step_ctrl <= wdata_i;
         end
         if (wr_sel) begin
            input_sel <= wdata_i & INPUT_SEL_WMASK;
         end
         if (wr_mask) begin
            mask <= wdata_i[EVT_W-1:0];
         end
         evt <= next_evt;
         rdata_o <= rd_i ? read_value : 32'h0000_0000;
         irq_o <= |(next_evt & mask);
      end
   end

   // ****************************************************************
   // Step sequencer
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         state <= ST_IDLE;
         step <= 3'h0;
         conv_start_o <= 1'b0;
         conv_input_o <= 2'h0;
         conv_temp_o <= 1'b0;
         conv_diff_o <= 1'b0;
      end else begin
         conv_start_o <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (start_req) begin
                  step <= 3'h0;
                  state <= ST_REQ;
               end
            end
            ST_REQ: begin
               conv_start_o <= 1'b1;
               conv_input_o <= cur_mux;
               conv_temp_o <= cur_grp[BIT_TEMP];
               conv_diff_o <= cur_grp[BIT_DIFF] && !cur_grp[BIT_TEMP];
               state <= ST_WAIT;
            end
            ST_WAIT: begin
               if (done_rise) begin
                  if (last_step) begin
                     state <= ST_IDLE;
                  end else begin
                     step <= step + 3'h1;
                     state <= ST_REQ;
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // ****************************************************************
   // Result FIFO
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         wr_ptr <= 3'h0;
         rd_ptr <= 3'h0;
         count <= 4'h0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 3'h1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 3'h1;
         end
         count <= next_count;
      end
   end

   always_ff @(posedge clk_i) begin
      if (push) begin
         fifo_mem[wr_ptr] <= data_sync;
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   sequence s_go;
      (state == ST_IDLE) && start_req;
   endsequence

   sequence s_request;
      (state == ST_REQ) ##1 (conv_start_o && (state == ST_WAIT));
   endsequence

   property p_go_request;
      @(posedge clk_i) disable iff (!rst_n_i)
         s_go |=> s_request;
   endproperty
   a_go_request: assert property (p_go_request) else $error("start did not request step");

   property p_source;
      @(posedge clk_i) disable iff (!rst_n_i)
         conv_start_o |-> (conv_temp_o == cur_grp[BIT_TEMP]) && (conv_input_o == cur_mux);
   endproperty
   a_source: assert property (p_source) else $error("wrong source for step");

   property p_diff;
      @(posedge clk_i) disable iff (!rst_n_i)
         (conv_start_o && !conv_temp_o) |-> (conv_diff_o == cur_grp[BIT_DIFF]);
   endproperty
   a_diff: assert property (p_diff) else $error("differential select mismatch");

   property p_temp_single;
      @(posedge clk_i) disable iff (!rst_n_i)
         conv_temp_o |-> !conv_diff_o;
   endproperty
   a_temp_single: assert property (p_temp_single) else $error("sensor sampled differentially");

   property p_raw_set;
      @(posedge clk_i) disable iff (!rst_n_i)
         raw_cause |=> evt[EVT_RAW];
   endproperty
   a_raw_set: assert property (p_raw_set) else $error("raw flag not raised");

   property p_raw_cause;
      @(posedge clk_i) disable iff (!rst_n_i)
         $rose(evt[EVT_RAW]) |-> $past(raw_cause);
   endproperty
   a_raw_cause: assert property (p_raw_cause) else $error("raw flag without enabled step");

   property p_irq_mask;
      @(posedge clk_i) disable iff (!rst_n_i)
         (next_evt == 3'h1) && !mask[EVT_RAW] && !wr_mask |=> !irq_o;
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("masked raw flag reached irq");

   property p_irq_pass;
      @(posedge clk_i) disable iff (!rst_n_i)
         evt[EVT_RAW] && mask[EVT_RAW] && !wr_status && !wr_mask |=> irq_o;
   endproperty
   a_irq_pass: assert property (p_irq_pass) else $error("unmasked raw flag missing");

   property p_end_stop;
      @(posedge clk_i) disable iff (!rst_n_i)
         step_done && last_step |=> (state == ST_IDLE) ##1 !conv_start_o;
   endproperty
   a_end_stop: assert property (p_end_stop) else $error("step after end converted");

   property p_next_step;
      @(posedge clk_i) disable iff (!rst_n_i)
         step_done && !last_step |=> (state == ST_REQ) && (step == $past(step) + 3'h1);
   endproperty
   a_next_step: assert property (p_next_step) else $error("sequence did not advance");

   property p_hard_end;
      @(posedge clk_i) disable iff (!rst_n_i)
         step_done && (step == LAST_STEP) |=> (state == ST_IDLE);
   endproperty
   a_hard_end: assert property (p_hard_end) else $error("final step not ended");

   property p_overflow;
      @(posedge clk_i) disable iff (!rst_n_i)
         step_done && fifo_full && !rd_fifo |=> evt[EVT_OVF] && (count == FIFO_DEPTH);
   endproperty
   a_overflow: assert property (p_overflow) else $error("overflow not recorded");

   property p_underflow;
      @(posedge clk_i) disable iff (!rst_n_i)
         rd_fifo && fifo_empty |=> evt[EVT_UNF] && (rdata_o == 32'h0000_0000);
   endproperty
   a_underflow: assert property (p_underflow) else $error("underflow not recorded");

   property p_pop;
      @(posedge clk_i) disable iff (!rst_n_i)
         pop && !push |=> (count == $past(count) - 4'h1) && (rd_ptr == $past(rd_ptr) + 3'h1);
   endproperty
   a_pop: assert property (p_pop) else $error("read did not remove entry");

   property p_result_width;
      @(posedge clk_i) disable iff (!rst_n_i)
         rd_fifo |=> (rdata_o[DATA_W-1:RESULT_W] == 22'h00_0000);
   endproperty
   a_result_width: assert property (p_result_width) else $error("result upper bits set");

   property p_first_step;
      @(posedge clk_i) disable iff (!rst_n_i)
         s_go |=> (step == 3'h0);
   endproperty
   a_first_step: assert property (p_first_step) else $error("bad first step");

   property p_start_pulse;
      @(posedge clk_i) disable iff (!rst_n_i)
         conv_start_o |=> !conv_start_o;
   endproperty
   a_start_pulse: assert property (p_start_pulse) else $error("request too long");

   property p_wait_hold;
      @(posedge clk_i) disable iff (!rst_n_i)
         (state == ST_WAIT) && !done_rise |=> (state == ST_WAIT) && (step == $past(step));
   endproperty
   a_wait_hold: assert property (p_wait_hold) else $error("step moved early");

   property p_fifo_write;
      @(posedge clk_i) disable iff (!rst_n_i)
         push |=> (fifo_mem[$past(wr_ptr)] == $past(data_sync));
   endproperty
   a_fifo_write: assert property (p_fifo_write) else $error("result not stored");

   property p_read_head;
      @(posedge clk_i) disable iff (!rst_n_i)
         pop |=> (rdata_o == {22'h00_0000, $past(fifo_mem[rd_ptr])});
   endproperty
   a_read_head: assert property (p_read_head) else $error("read not from head");

   property p_rdata_idle;
      @(posedge clk_i) disable iff (!rst_n_i)
         !rd_i |=> (rdata_o == 32'h0000_0000);
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read");

   property p_status_clear;
      @(posedge clk_i) disable iff (!rst_n_i)
         wr_status && wdata_i[EVT_RAW] && !raw_cause |=> !evt[EVT_RAW];
   endproperty
   a_status_clear: assert property (p_status_clear) else $error("flag not cleared");

endmodule : adc_seq0_ctrl
`default_nettype wire

//--- testbench/adc_conv_model.sv
// Behavioural model of the converter and its analog input multiplexer.
`timescale 1ns/10ps
`default_nettype none
module adc_conv_model (
   input wire logic clk_i,
   input wire logic start_i,
   input wire logic [1:0] input_i,
   input wire logic temp_i,
   input wire logic diff_i,
   output logic done_o,
   output logic [9:0] data_o
);
   // ****************************************************************
   // Conversion engine
   // ****************************************************************
   logic [5:0] count;

   // Result carries the source selection and a running count.
   // Odd conversions answer slowly, even ones promptly.
   initial begin
      done_o = 1'b0;
      data_o = 10'h3ff;
      count = 6'h00;
      forever begin
         @(posedge clk_i);
         if (start_i === 1'b1) begin
            data_o <= ~data_o;
            repeat (count[0] ? 9 : 2) @(posedge clk_i);
            data_o <= {temp_i, diff_i, input_i, count};
            count <= count + 6'h01;
            @(posedge clk_i);
            done_o <= 1'b1;
            repeat (3) @(posedge clk_i);
            done_o <= 1'b0;
         end
      end
   end
endmodule : adc_conv_model
`default_nettype wire

//--- testbench/adc_sequence0_control_fifo_test.sv
// Self-checking testbench for the sequence 0 control and result FIFO.
`timescale 1ns/10ps
`default_nettype none
module adc_sequence0_control_fifo_test;
   import adc_seq0_pkg::*;
   typedef struct {
      logic [DATA_W-1:0] ctrl;
      logic [DATA_W-1:0] sel;
      logic [EVT_W-1:0] mask;
   } row_s;
   logic clk, rst_n, wr, rd, irq, cstart, ctemp, cdiff, cdone;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata, rdata;
   logic [MUX_W-1:0] cinput;
   logic [RESULT_W-1:0] cdata;
   int failures = 0;
   int check_count = 0;
   int conv_total = 0;
   int cycles = 0;
   logic raw;
   logic [DATA_W-1:0] exp_q[$];
   row_s rows[4] = '{
      '{32'h0000_0002, 32'h0000_0001, 3'h1},
      '{32'h0000_00a4, 32'h0000_0032, 3'h1},
      '{32'hffff_f295, 32'h3333_3121, 3'h0},
      '{32'h6444_4444, 32'h0123_0123, 3'h1}};

   adc_seq0_ctrl u_adc_seq0_ctrl (.clk_i(clk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .irq_o(irq), .conv_start_o(cstart),
      .conv_input_o(cinput), .conv_temp_o(ctemp), .conv_diff_o(cdiff), .conv_done_i(cdone),
      .conv_data_i(cdata));
   adc_conv_model u_adc_conv_model (.clk_i(clk), .start_i(cstart), .input_i(cinput),
      .temp_i(ctemp), .diff_i(cdiff), .done_o(cdone), .data_o(cdata));

   // ****************************************************************
   // Bus and checking tasks
   // ****************************************************************
   task automatic check(input string what, input logic [DATA_W-1:0] seen,
                        input logic [DATA_W-1:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %0s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rd_reg

   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp,
                         input string what);
      logic [DATA_W-1:0] d;
      rd_reg(a, d);
      check(what, d, exp);
   endtask : rd_chk

   task automatic run_seq();
      logic [DATA_W-1:0] d;
      int n;
      wr_reg(OFS_START, 32'h0000_0001);
      n = 0;
      do begin
         rd_reg(OFS_START, d);
         n++;
      end while (d[BIT_GO] !== 1'b0 && n < 300);
      check("idle", 32'(d[BIT_GO]), 32'h0000_0000);
      repeat (4) @(posedge clk);
   endtask : run_seq

   // Builds the expected results of one sequence from the step fields.
   task automatic predict(input row_s r);
      logic [3:0] nib;
      logic t;
      exp_q.delete();
      raw = 1'b0;
      for (int s = 0; s < 8; s++) begin
         nib = r.ctrl[4*s +: 4];
         t = nib[BIT_TEMP];
         exp_q.push_back({22'h0, t, nib[BIT_DIFF] & ~t, r.sel[4*s +: 2], 6'(conv_total)});
         conv_total++;
         raw = raw | nib[BIT_IRQ_EN];
         if (nib[BIT_END] === 1'b1) break;
      end
   endtask : predict

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : tally_and_finish

   // ****************************************************************
   // Clock, timeout and main sequence
   // ****************************************************************
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   initial begin
      forever begin
         @(posedge clk);
         cycles++;
         if (cycles == 20000) begin
            failures++;
            $display("timeout reached");
            tally_and_finish();
         end
      end
   end

   initial begin
      rst_n = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = '0;
      wdata = '0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      rd_chk(OFS_STEP_CTRL, STEP_CTRL_RST, "ctrl reset");
      rd_chk(OFS_INPUT_SEL, INPUT_SEL_RST, "sel reset");
      rd_chk(OFS_INT_MASK, 32'h0000_0000, "mask reset");
      rd_chk(OFS_INT_STATUS, 32'h0000_0000, "status reset");
      rd_chk(OFS_RESULT, 32'h0000_0000, "empty read");
      rd_chk(OFS_UNDERFLOW, 32'h0000_0001, "underflow");
      wr_reg(OFS_UNDERFLOW, 32'h0000_0001);
      rd_chk(OFS_UNDERFLOW, 32'h0000_0000, "underflow clear");
      wr_reg(OFS_INPUT_SEL, 32'hffff_ffff);
      rd_chk(OFS_INPUT_SEL, INPUT_SEL_WMASK, "sel reserved");
      wr_reg(12'h0fc, 32'hffff_ffff);
      rd_chk(12'h0fc, 32'h0000_0000, "unmapped");
      $display("test reset done");
      foreach (rows[i]) begin
         wr_reg(OFS_INPUT_SEL, rows[i].sel);
         wr_reg(OFS_STEP_CTRL, rows[i].ctrl);
         wr_reg(OFS_INT_MASK, 32'(rows[i].mask));
         wr_reg(OFS_INT_STATUS, 32'h0000_0007);
         rd_chk(OFS_STEP_CTRL, rows[i].ctrl, "ctrl");
         predict(rows[i]);
         run_seq();
         rd_chk(OFS_INT_STATUS, 32'(raw), "raw flag");
         check("irq", 32'(irq), 32'(raw & rows[i].mask[EVT_RAW]));
         foreach (exp_q[k]) begin
            rd_chk(OFS_RESULT, exp_q[k], "result");
         end
         rd_chk(OFS_RESULT, 32'h0000_0000, "drained");
         wr_reg(OFS_INT_STATUS, 32'h0000_0007);
         $display("test row %0d done", i);
      end
      wr_reg(OFS_STEP_CTRL, 32'h2000_0000);
      wr_reg(OFS_INPUT_SEL, 32'h0000_0000);
      wr_reg(OFS_INT_MASK, 32'h0000_0002);
      predict('{32'h2000_0000, 32'h0000_0000, 3'h0});
      run_seq();
      run_seq();
      conv_total += 8;
      check("overflow irq", 32'(irq), 32'h0000_0001);
      rd_chk(OFS_OVERFLOW, 32'h0000_0001, "overflow");
      rd_chk(OFS_UNDERFLOW, 32'h0000_0000, "no underflow");
      foreach (exp_q[k]) begin
         rd_chk(OFS_RESULT, exp_q[k], "full result");
      end
      rd_chk(OFS_RESULT, 32'h0000_0000, "after full");
      wr_reg(OFS_OVERFLOW, 32'h0000_0001);
      rd_chk(OFS_OVERFLOW, 32'h0000_0000, "overflow clear");
      check("irq cleared", 32'(irq), 32'h0000_0000);
      $display("test overflow done");
      wr_reg(OFS_INT_MASK, 32'h0000_0001);
      wr_reg(OFS_STEP_CTRL, 32'h6000_0004);
      wr_reg(OFS_START, 32'h0000_0001);
      repeat (20) @(posedge clk);
      check("irq before reset", 32'(irq), 32'h0000_0001);
      rst_n <= 1'b0;
      repeat (12) @(posedge clk);
      check("irq in reset", 32'(irq), 32'h0000_0000);
      rst_n <= 1'b1;
      rd_chk(OFS_START, 32'h0000_0000, "idle after reset");
      rd_chk(OFS_STEP_CTRL, STEP_CTRL_RST, "ctrl after reset");
      rd_chk(OFS_INT_STATUS, 32'h0000_0000, "status after reset");
      rd_chk(OFS_RESULT, 32'h0000_0000, "fifo after reset");
      $display("test mid-run reset done");
      tally_and_finish();
   end
endmodule : adc_sequence0_control_fifo_test
`default_nettype wire
